//--- verilog/vfdc_map.svh
`ifndef VFDC_MAP_SVH
`define VFDC_MAP_SVH
// serial word framing
`define VFDC_WORD_BITS 8
// command opcodes in bits 7..4 of the first byte
`define VFDC_OP_CHAR 4'h8
`define VFDC_OP_GLYPH 4'h4
`define VFDC_OP_SYMBOL 4'hc
`define VFDC_OP_DUTY 4'ha
`define VFDC_OP_DIGITS 4'h6
`define VFDC_OP_LIGHTS 4'he
// field positions
`define VFDC_OP_MSB 7
`define VFDC_OP_LSB 4
`define VFDC_ARG_MSB 3
`define VFDC_LIGHT_OFF_BIT 0
`define VFDC_LIGHT_ON_BIT 1
// reset values
`define VFDC_RST_ADDR 4'h0
`define VFDC_RST_DUTY 4'h0
`define VFDC_RST_DIGITS 4'h0
`define VFDC_RST_COUNT 5'h10
`endif

//--- verilog/vfdc_pkg.sv
package vfdc_pkg;
	// decoder state: which kind of byte comes next
	typedef enum logic [2:0] {
		VFDC_ST_CMD,
		VFDC_ST_CHAR,
		VFDC_ST_GLYPH_LO,
		VFDC_ST_GLYPH_HI,
		VFDC_ST_SYMBOL,
		VFDC_ST_TEST
	} vfdc_state_t;
endpackage

//--- verilog/vfdc_shift_rx.sv
`timescale 1ns/100ps
`include "vfdc_map.svh"
// serial receiver: syncs pins, shifts lsb first, pulses per whole byte
module vfdc_shift_rx
(
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_cs_n,
	input wire logic i_shift_clock_n,
	input wire logic i_serial_data_in,
	output logic o_byte_valid,
	output logic [7:0] o_byte,
	output logic o_cs_active
);
	logic [1:0] cs_sync_r; // two sync stages, select needs no edge history
	logic [2:0] ck_sync_r; // clock sync plus previous value for edge detect
	logic [1:0] da_sync_r;
	logic [7:0] shift_r;
	logic [7:0] shift_nxt;
	logic [2:0] cnt_r; // bits gathered in the current byte
	logic [2:0] cnt_nxt;
	logic valid_r;
	logic valid_nxt;
	logic [7:0] byte_r;
	logic [7:0] byte_nxt;
	logic rise;
	logic sel;

	// only stage 2 onward is read by logic
	assign rise = ck_sync_r[1] & ~ck_sync_r[2];
	assign sel = ~cs_sync_r[1];

	// shifter next-state
	always_comb
	begin
		shift_nxt = shift_r;
		cnt_nxt = cnt_r;
		valid_nxt = 1'b0;
		byte_nxt = byte_r;
		if (!sel)
		begin
			// partial byte dropped, realign on next select
			cnt_nxt = 3'h0;
		end
		else if (rise)
		begin
			// data enters at the top, so the first bit ends at bit 0
			shift_nxt = {da_sync_r[1], shift_r[7:1]};
			cnt_nxt = cnt_r + 3'h1;
			if (cnt_r == 3'h7)
			begin
				// internal load strobe, host gives none
				valid_nxt = 1'b1;
				byte_nxt = {da_sync_r[1], shift_r[7:1]};
			end
		end
	end

	// registers; data sync is as deep as the clock's newest stage so setup holds
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			cs_sync_r <= 2'h3;
			ck_sync_r <= 3'h7;
			da_sync_r <= 2'h0;
			shift_r <= 8'h00;
			cnt_r <= 3'h0;
			valid_r <= 1'b0;
			byte_r <= 8'h00;
		end
		else
		begin
			cs_sync_r <= {cs_sync_r[0], i_cs_n};
			ck_sync_r <= {ck_sync_r[1:0], i_shift_clock_n};
			da_sync_r <= {da_sync_r[0], i_serial_data_in};
			shift_r <= shift_nxt;
			cnt_r <= cnt_nxt;
			valid_r <= valid_nxt;
			byte_r <= byte_nxt;
		end
	end

	assign o_byte_valid = valid_r;
	assign o_byte = byte_r;
	assign o_cs_active = sel;
endmodule // vfdc_shift_rx

//--- verilog/vfdc_decoder.sv
`timescale 1ns/100ps
`include "vfdc_map.svh"
module vfdc_decoder
#(
	parameter int DIGITS = 16, // digit positions
	parameter int GLYPHS = 16 // user glyph entries
)
(
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_cs_n,
	input wire logic i_shift_clock_n,
	input wire logic i_serial_data_in,
	input wire logic [3:0] i_scan_digit, // digit the scan logic reads
	input wire logic [15:0] i_rom_pattern, // glyph rom answer for o_rom_code
	output logic [3:0] o_duty, // brightness, n/16
	output logic [4:0] o_digit_count, // 1..16 digits
	output logic o_lights_on,
	output logic o_lights_off,
	output logic [7:0] o_rom_code, // code presented to glyph rom
	output logic [15:0] o_anode_output,
	output logic [1:0] o_symbol_output,
	output logic o_test_mode,
	output logic o_byte_strobe // one cycle per committed byte
);
	// receiver hand-off, all on the core clock
	logic byte_valid;
	logic [7:0] rx_byte;
	logic cs_active;
	// the three rams, written one item at a time
	logic [7:0] char_code_ram [DIGITS]; // contents undefined after reset
	logic [15:0] user_glyph_ram [GLYPHS];
	logic [1:0] symbol_ram [DIGITS];
	// command context and settings
	vfdc_pkg::vfdc_state_t st_r;
	vfdc_pkg::vfdc_state_t st_nxt;
	logic [3:0] addr_r; // shared pointer of the ram being written
	logic [3:0] addr_nxt;
	logic [7:0] glyph_lo_r; // first half of a glyph item
	logic [7:0] glyph_lo_nxt;
	logic [3:0] duty_r;
	logic [3:0] duty_nxt;
	logic [3:0] digits_r;
	logic [3:0] digits_nxt;
	logic on_r;
	logic on_nxt;
	logic off_r;
	logic off_nxt;
	// one-cycle write enables from the decoder
	logic wr_char;
	logic wr_glyph;
	logic wr_sym;
	// display read side
	logic [7:0] code_r; // code of scanned digit, pipeline stage
	logic [15:0] anode_r;
	logic [1:0] sym_r;
	logic strobe_r;
	// decoded copies, so every output leaves a flip-flop
	logic [4:0] count_r; // digits actually scanned, 1..16
	logic [4:0] count_nxt;
	logic test_r; // factory test state flag
	logic test_nxt;

	// returns the opcode nibble of a first byte
	function automatic logic [3:0] op_of(input logic [7:0] b);
		op_of = b[`VFDC_OP_MSB:`VFDC_OP_LSB];
	endfunction

	vfdc_shift_rx u_rx
	(
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_cs_n(i_cs_n),
		.i_shift_clock_n(i_shift_clock_n),
		.i_serial_data_in(i_serial_data_in),
		.o_byte_valid(byte_valid),
		.o_byte(rx_byte),
		.o_cs_active(cs_active)
	);

	// command decode next-state
	always_comb
	begin
		st_nxt = st_r;
		addr_nxt = addr_r;
		glyph_lo_nxt = glyph_lo_r;
		duty_nxt = duty_r;
		digits_nxt = digits_r;
		on_nxt = on_r;
		off_nxt = off_r;
		wr_char = 1'b0;
		wr_glyph = 1'b0;
		wr_sym = 1'b0;
		if (!cs_active)
		begin
			// select high ends any command; next byte is a first byte
			if (st_r != vfdc_pkg::VFDC_ST_GLYPH_HI)
			begin
				st_nxt = vfdc_pkg::VFDC_ST_CMD;
			end
			else
			begin
				// a half glyph item is dropped, the address is kept
				st_nxt = vfdc_pkg::VFDC_ST_CMD;
			end
		end
		// one step per committed byte
		else if (byte_valid)
		begin
			case (st_r)
				vfdc_pkg::VFDC_ST_CMD:
				begin
					// first byte: opcode in the high nibble, argument in the low
					case (op_of(rx_byte))
						`VFDC_OP_CHAR:
						begin
							addr_nxt = rx_byte[`VFDC_ARG_MSB:0];
							st_nxt = vfdc_pkg::VFDC_ST_CHAR;
						end
						`VFDC_OP_GLYPH:
						begin
							addr_nxt = rx_byte[`VFDC_ARG_MSB:0];
							st_nxt = vfdc_pkg::VFDC_ST_GLYPH_LO;
						end
						`VFDC_OP_SYMBOL:
						begin
							addr_nxt = rx_byte[`VFDC_ARG_MSB:0];
							st_nxt = vfdc_pkg::VFDC_ST_SYMBOL;
						end
						`VFDC_OP_DUTY:
						begin
							duty_nxt = rx_byte[`VFDC_ARG_MSB:0];
						end
						`VFDC_OP_DIGITS:
						begin
							digits_nxt = rx_byte[`VFDC_ARG_MSB:0];
						end
						`VFDC_OP_LIGHTS:
						begin
							// bits 2..3 ignored
							off_nxt = rx_byte[`VFDC_LIGHT_OFF_BIT];
							on_nxt = rx_byte[`VFDC_LIGHT_ON_BIT];
						end
						default:
						begin
							// undefined code: swallow bytes until select rises
							st_nxt = vfdc_pkg::VFDC_ST_TEST;
						end
					endcase
				end
				// each further byte is one character code
				vfdc_pkg::VFDC_ST_CHAR:
				begin
					wr_char = 1'b1;
					addr_nxt = addr_r + 4'h1;
				end
				// low half of the pattern waits for its partner
				vfdc_pkg::VFDC_ST_GLYPH_LO:
				begin
					glyph_lo_nxt = rx_byte;
					st_nxt = vfdc_pkg::VFDC_ST_GLYPH_HI;
				end
				vfdc_pkg::VFDC_ST_GLYPH_HI:
				begin
					// both bytes make one item, so increment only now
					wr_glyph = 1'b1;
					addr_nxt = addr_r + 4'h1;
					st_nxt = vfdc_pkg::VFDC_ST_GLYPH_LO;
				end
				// only the two low bits of a symbol byte count
				vfdc_pkg::VFDC_ST_SYMBOL:
				begin
					wr_sym = 1'b1;
					addr_nxt = addr_r + 4'h1;
				end
				// factory test state: nothing is stored
				vfdc_pkg::VFDC_ST_TEST:
				begin
					st_nxt = vfdc_pkg::VFDC_ST_TEST;
				end
				// unused encodings fall back to a first byte
				default:
				begin
					st_nxt = vfdc_pkg::VFDC_ST_CMD;
				end
			endcase
		end
		// decoded ahead of the register so the outputs carry no logic
		count_nxt = (digits_nxt == 4'h0) ? 5'h10 : {1'b0, digits_nxt};
		test_nxt = (st_nxt == vfdc_pkg::VFDC_ST_TEST);
	end

	// control registers, constants only under reset
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			st_r <= vfdc_pkg::VFDC_ST_CMD;
			addr_r <= `VFDC_RST_ADDR;
			glyph_lo_r <= 8'h00;
			duty_r <= `VFDC_RST_DUTY;
			digits_r <= `VFDC_RST_DIGITS;
			on_r <= 1'b0;
			off_r <= 1'b0;
			// a zero digit register still reads as sixteen
			count_r <= `VFDC_RST_COUNT;
			test_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			addr_r <= addr_nxt;
			glyph_lo_r <= glyph_lo_nxt;
			duty_r <= duty_nxt;
			digits_r <= digits_nxt;
			on_r <= on_nxt;
			off_r <= off_nxt;
			count_r <= count_nxt;
			test_r <= test_nxt;
		end
	end

	// ram writes; no reset so they map onto plain memory
	always_ff @(posedge i_core_clk)
	begin
		// the pointer is the one in use before this item's increment
		if (wr_char)
		begin
			char_code_ram[addr_r] <= rx_byte;
		end
		if (wr_glyph)
		begin
			user_glyph_ram[addr_r] <= {rx_byte, glyph_lo_r};
		end
		if (wr_sym)
		begin
			symbol_ram[addr_r] <= rx_byte[1:0];
		end
	end

	// display read pipeline: code, then pattern; outputs low until reset ends
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			code_r <= 8'h00;
			anode_r <= 16'h0000;
			sym_r <= 2'h0;
			strobe_r <= 1'b0;
		end
		else
		begin
			code_r <= char_code_ram[i_scan_digit];
			// codes below GLYPHS come from user ram, the rest from rom
			if (code_r < 8'(GLYPHS))
			begin
				anode_r <= user_glyph_ram[code_r[3:0]];
			end
			else
			begin
				anode_r <= i_rom_pattern;
			end
			// symbols bypass glyph translation, one cycle after the digit
			sym_r <= symbol_ram[i_scan_digit];
			// mirrors the internal load strobe for the scan side
			strobe_r <= byte_valid & cs_active;
		end
	end

	// every output is a plain flip-flop
	assign o_duty = duty_r;
	assign o_digit_count = count_r;
	assign o_lights_on = on_r;
	assign o_lights_off = off_r;
	assign o_rom_code = code_r;
	assign o_anode_output = anode_r;
	assign o_symbol_output = sym_r;
	assign o_test_mode = test_r;
	assign o_byte_strobe = strobe_r;
endmodule // vfdc_decoder

//--- bench/vfdc_sva.sv
`timescale 1ns/100ps
// pin-level checks on the decoder
module vfdc_sva
(
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_cs_n,
	input wire logic [3:0] o_duty,
	input wire logic [4:0] o_digit_count,
	input wire logic o_lights_on,
	input wire logic o_lights_off,
	input wire logic [15:0] o_anode_output,
	input wire logic [1:0] o_symbol_output,
	input wire logic o_test_mode,
	input wire logic o_byte_strobe
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	// frames are far longer than one cycle, so a pulse never repeats at once
	strobe_pulse_a: assert property (o_byte_strobe |=> !o_byte_strobe)
		else $error("byte strobe held over one cycle");
	idle_quiet_a: assert property (i_cs_n [*8] |-> !o_byte_strobe)
		else $error("byte strobe while deselected");
	test_exit_a: assert property (i_cs_n [*6] |-> !o_test_mode)
		else $error("test state outlived select");
	test_entry_a: assert property ($rose(o_test_mode) |-> o_byte_strobe)
		else $error("test state entered without a byte");
	duty_hold_a: assert property ($changed(o_duty) |-> o_byte_strobe)
		else $error("duty moved without a byte");
	digits_hold_a: assert property ($changed(o_digit_count) |-> o_byte_strobe)
		else $error("digit count moved without a byte");
	lights_hold_a: assert property ($changed({o_lights_on, o_lights_off}) |-> o_byte_strobe)
		else $error("lights moved without a byte");
	count_range_a: assert property (o_digit_count != 5'h00 && o_digit_count <= 5'h10)
		else $error("digit count out of range");
	reset_state_a: assert property ($fell(i_rst) |-> o_duty == 4'h0 && o_digit_count == 5'h10
		&& !o_lights_on && !o_lights_off && o_anode_output == 16'h0000 && o_symbol_output == 2'h0)
		else $error("outputs not at reset values");
endmodule // vfdc_sva
bind vfdc_decoder vfdc_sva u_sva (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_cs_n(i_cs_n),
	.o_duty(o_duty), .o_digit_count(o_digit_count), .o_lights_on(o_lights_on),
	.o_lights_off(o_lights_off), .o_anode_output(o_anode_output),
	.o_symbol_output(o_symbol_output), .o_test_mode(o_test_mode), .o_byte_strobe(o_byte_strobe));

//--- bench/vfdc_host.sv
`timescale 1ns/100ps
// host side: select, shift clock and serial data
module vfdc_host
(
	input wire logic i_core_clk,
	output logic o_cs_n,
	output logic o_shift_clock_n,
	output logic o_serial_data_in
);
	// idle: deselected, shift clock parked high
	initial
	begin
		o_cs_n = 1'b1;
		o_shift_clock_n = 1'b1;
		o_serial_data_in = 1'b0;
	end
	task automatic wait_n(input int n);
		repeat (n) @(negedge i_core_clk);
	endtask
	// lsb first, 200 ns period; data only moves while the clock is low
	task automatic send(input logic [7:0] b, input int n);
		for (int k = 0; k < n; k++)
		begin
			o_shift_clock_n = 1'b0;
			o_serial_data_in = b[k];
			wait_n(4);
			o_shift_clock_n = 1'b1;
			wait_n(4);
		end
	endtask
	// released data line flips so a stale bit is never mistaken for a held one
	task automatic select(input logic on);
		wait_n(4);
		o_cs_n = !on;
		if (!on)
			o_serial_data_in = !o_serial_data_in;
		wait_n(4);
	endtask
endmodule // vfdc_host

//--- bench/tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb;
	logic i_core_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [3:0] i_scan_digit = 4'h0;
	logic cs_n, sclk, sdata;
	logic [3:0] duty;
	logic [4:0] digits;
	logic lon, loff, tmode;
	logic [7:0] code;
	logic [15:0] anode;
	logic [1:0] sym;
	logic strobe;
	int strobes = 0; // committed bytes seen on the strobe
	int failures = 0;
	int checks = 0;
	int cycles = 0;
	vfdc_host u_host (.i_core_clk(i_core_clk), .o_cs_n(cs_n), .o_shift_clock_n(sclk),
		.o_serial_data_in(sdata));
	// rom stand-in: pattern is the code and its inverse
	vfdc_decoder uut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_cs_n(cs_n),
		.i_shift_clock_n(sclk), .i_serial_data_in(sdata), .i_scan_digit(i_scan_digit),
		.i_rom_pattern({~code, code}), .o_duty(duty), .o_digit_count(digits),
		.o_lights_on(lon), .o_lights_off(loff), .o_rom_code(code), .o_anode_output(anode),
		.o_symbol_output(sym), .o_test_mode(tmode), .o_byte_strobe(strobe));
	initial
	begin
		forever #12.5 i_core_clk = ~i_core_clk;
	end
	// count strobe pulses where they are settled, away from the launching edge
	always @(negedge i_core_clk)
	begin
		if (strobe === 1'b1)
			strobes++;
	end
	// hang guard
	always @(posedge i_core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// n whole bytes in one frame, lowest byte first
	task automatic burst(input logic [39:0] w, input int n);
		u_host.select(1'b1);
		for (int i = 0; i < n; i++)
			u_host.send(w[8*i +: 8], 8);
		u_host.select(1'b0);
	endtask
	// scan a digit and let both pipeline stages fill
	task automatic look(input logic [3:0] d);
		i_scan_digit = d;
		repeat (3) @(negedge i_core_clk);
	endtask
	task automatic check_reset;
		`CHK("duty", 4'h0, duty)
		`CHK("digits", 5'h10, digits)
		`CHK("lights", 2'b00, {lon, loff})
		`CHK("test", 1'b0, tmode)
	endtask
	task automatic t_settings;
		for (int d = 0; d < 16; d++)
		begin
			burst(40'ha0 | d, 1);
			`CHK("duty", d[3:0], duty)
			burst(40'h60 | d, 1);
			`CHK("digits", (d == 0) ? 5'h10 : d[4:0], digits)
		end
	endtask
	task automatic t_lights;
		burst(40'he2, 1);
		`CHK("lights on", 2'b10, {lon, loff})
		burst(40'hed, 1);
		`CHK("lights off", 2'b01, {lon, loff})
	endtask
	// character and symbol writes wrap from address 15 to 0
	task automatic t_rams;
		int n0;
		n0 = strobes;
		burst(40'h56_78_12_34_4e, 5);
		burst(40'ha5_0f_0e_8f, 4);
		burst(40'h01_fe_cf, 3);
		`CHK("strobes", 12, strobes - n0)
		look(4'hf);
		`CHK("code 15", 8'h0e, code)
		`CHK("glyph 15", 16'h1234, anode)
		`CHK("symbol 15", 2'h2, sym)
		look(4'h0);
		`CHK("code 0", 8'h0f, code)
		`CHK("glyph 0", 16'h5678, anode)
		`CHK("symbol 0", 2'h1, sym)
		look(4'h1);
		`CHK("rom 1", 16'h5aa5, anode)
	endtask
	task automatic t_partial;
		int n0;
		n0 = strobes;
		u_host.select(1'b1);
		u_host.send(8'hff, 5);
		u_host.select(1'b0);
		`CHK("partial strobes", 0, strobes - n0)
		burst(40'ha9, 1);
		`CHK("duty after drop", 4'h9, duty)
	endtask
	task automatic t_test;
		u_host.select(1'b1);
		u_host.send(8'h10, 8);
		u_host.send(8'ha3, 8);
		`CHK("test mode", 1'b1, tmode)
		u_host.select(1'b0);
		`CHK("duty held", 4'h9, duty)
		`CHK("test left", 1'b0, tmode)
	endtask
	task automatic t_reset;
		i_rst = 1'b1;
		repeat (2) @(negedge i_core_clk);
		`CHK("anode in reset", 16'h0000, anode)
		`CHK("symbol in reset", 2'h0, sym)
		i_rst = 1'b0;
		repeat (3) @(negedge i_core_clk);
		check_reset();
	endtask
	// power-up reset first, then every setting is reprogrammed
	initial
	begin
		repeat (3) @(negedge i_core_clk);
		i_rst = 1'b0;
		repeat (3) @(negedge i_core_clk);
		check_reset();
		t_settings();
		t_lights();
		t_rams();
		t_partial();
		t_test();
		t_reset();
		tally_and_finish();
	end
endmodule // tb
